//--- logic/pdb_params.svh
// Constants for the PWM duty buffer update block
`ifndef PDB_PARAMS_SVH
`define PDB_PARAMS_SVH
`define PDB_W          16
`define PDB_FREE_PRE   16'hfffe
`define PDB_FREE_TOP   16'hffff
`define PDB_ZERO       16'h0000
`define PDB_ONE        16'h0001
`define PDB_CLK_NONE   2'h0
`endif

//--- logic/pdb_pkg.sv
// Types for the PWM duty buffer update block
package pdb_pkg;
	typedef enum logic [1:0] {PDB_IDLE, PDB_LOW_HELD, PDB_ARMED} pdb_wr_state_t;
	typedef enum logic {PDB_UP, PDB_DOWN} pdb_dir_t;
endpackage : pdb_pkg

//--- logic/pdb_cnt_if.sv
// Counter state shared between the counter and the update logic
`timescale 1ns/1ps
interface pdb_cnt_if;
	logic [15:0] count;
	logic        step;
	logic        at_top_step;
	logic        period_start;
	pdb_pkg::pdb_dir_t dir;
	modport cnt (output count, step, at_top_step, period_start, dir);
	modport usr (input count, step, at_top_step, period_start, dir);
endinterface : pdb_cnt_if

//--- logic/pdb_counter.sv
// Timer counter: up or up/down against the modulo limit
`timescale 1ns/1ps
`include "pdb_params.svh"
module pdb_counter (
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic        clk_en,
	input  wire logic        tick,
	input  wire logic        center_mode,
	input  wire logic [15:0] modulo,
	pdb_cnt_if.cnt           cif
);
	logic [15:0] count_reg;
	logic        down_reg;
	logic        free_run;
	logic [15:0] top;
	assign free_run = (modulo == `PDB_ZERO) || (modulo == `PDB_FREE_TOP);
	assign top      = free_run ? `PDB_FREE_TOP : modulo;
	assign cif.count = count_reg;
	assign cif.step  = tick;
	assign cif.dir   = down_reg ? pdb_pkg::PDB_DOWN : pdb_pkg::PDB_UP;
	// Update point is the up-step into the top value
	assign cif.at_top_step = tick && !down_reg && (count_reg == top - `PDB_ONE);
	assign cif.period_start = tick && (center_mode ? (down_reg && count_reg == `PDB_ONE)
		: (count_reg == top));

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			count_reg <= `PDB_ZERO;
			down_reg  <= 1'b0;
		end else if (clk_en && tick) begin
			if (center_mode) begin
				if (!down_reg && count_reg >= top - `PDB_ONE) begin
					count_reg <= top;
					down_reg  <= 1'b1;
				end else if (down_reg && count_reg <= `PDB_ONE) begin
					count_reg <= `PDB_ZERO;
					down_reg  <= 1'b0;
				end else if (down_reg)
					count_reg <= count_reg - `PDB_ONE;
				else
					count_reg <= count_reg + `PDB_ONE;
			end else begin
				down_reg  <= 1'b0;
				count_reg <= (count_reg >= top) ? `PDB_ZERO : count_reg + `PDB_ONE;
			end
		end
	end
endmodule : pdb_counter

//--- logic/pdb_duty_update.sv
// Buffered duty update for one PWM channel with two-byte write coherency
// Operation
// - Edge-aligned with a clock selected, a complete value moves to the active register on the step from modulo-1 to modulo.
// - With a free-running counter that update happens on the step from 0xfffe to 0xffff.
// - Center-aligned with a clock selected, a complete value likewise moves only at the step from modulo-1 to modulo.
// - Center-aligned, a nonzero value equal to modulo gives an output active for the whole period.
// - Center-aligned, a value of modulo-1 gives a duty just short of full, zero only when modulo is 1.
// - Center-aligned, a change from zero to nonzero keeps the old pattern until a new period begins.
// - Center-aligned, a change from nonzero to zero finishes the current period with the old duty.
// - In background debug, a status/control write clears a half-written modulo value.
// - Any status/control write discards a half-written channel value.
`timescale 1ns/1ps
`include "pdb_params.svh"
module pdb_duty_update (
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic        clk_en,
	input  wire logic        tick,
	input  wire logic [1:0]  counter_clock_source_select,
	input  wire logic        center_mode,
	input  wire logic        background_debug_mode,
	input  wire logic        timer_status_control_wr,
	input  wire logic        value_wr_lo,
	input  wire logic        value_wr_hi,
	input  wire logic        modulo_wr_lo,
	input  wire logic        modulo_wr_hi,
	input  wire logic [7:0]  wr_data,
	output logic      [15:0] channel_compare_value,
	output logic      [15:0] counter_modulo_limit,
	output logic      [15:0] count,
	output logic             pwm_out,
	output logic             value_pending,
	output logic             modulo_pending
);
	////////////////////////////////////////////////////////////////////
	pdb_cnt_if cif ();
	logic clk_on;
	logic eff_tick;
	assign clk_on   = counter_clock_source_select != `PDB_CLK_NONE;
	// Counting is suspended in background debug
	assign eff_tick = tick && clk_on && !background_debug_mode;
	assign count    = cif.count;

	pdb_counter u_cnt (
		.ref_clk     (ref_clk),
		.srst        (srst),
		.clk_en      (clk_en),
		.tick        (eff_tick),
		.center_mode (center_mode),
		.modulo      (counter_modulo_limit),
		.cif         (cif)
	);

	////////////////////////////////////////////////////////////////////
	// Channel value write buffer
	pdb_pkg::pdb_wr_state_t wr_state_reg;
	logic [7:0]  lo_byte_reg;
	logic [15:0] buf_reg;
	logic        take_now;
	assign take_now = (wr_state_reg == pdb_pkg::PDB_ARMED) && (!clk_on || cif.at_top_step);
	assign value_pending = wr_state_reg != pdb_pkg::PDB_IDLE;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			wr_state_reg <= pdb_pkg::PDB_IDLE;
			lo_byte_reg  <= 8'h00;
			buf_reg      <= `PDB_ZERO;
		end else if (clk_en) begin
			if (timer_status_control_wr)
				wr_state_reg <= pdb_pkg::PDB_IDLE;
			else if (value_wr_hi && wr_state_reg == pdb_pkg::PDB_LOW_HELD) begin
				buf_reg      <= {wr_data, lo_byte_reg};
				wr_state_reg <= pdb_pkg::PDB_ARMED;
			end else if (value_wr_lo) begin
				lo_byte_reg  <= wr_data;
				wr_state_reg <= pdb_pkg::PDB_LOW_HELD;
			end else if (take_now)
				wr_state_reg <= pdb_pkg::PDB_IDLE;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst)
			channel_compare_value <= `PDB_ZERO;
		else if (clk_en && take_now && !timer_status_control_wr)
			channel_compare_value <= buf_reg;
	end

	////////////////////////////////////////////////////////////////////
	// Modulo write coherency
	logic [7:0] mod_lo_reg;
	logic       mod_half_reg;
	assign modulo_pending = mod_half_reg;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			mod_lo_reg           <= 8'h00;
			mod_half_reg         <= 1'b0;
			counter_modulo_limit <= `PDB_ZERO;
		end else if (clk_en) begin
			if (timer_status_control_wr && background_debug_mode)
				mod_half_reg <= 1'b0;
			else if (modulo_wr_hi && mod_half_reg) begin
				counter_modulo_limit <= {wr_data, mod_lo_reg};
				mod_half_reg         <= 1'b0;
			end else if (modulo_wr_lo) begin
				mod_lo_reg   <= wr_data;
				mod_half_reg <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Output: with a clock selected the active value only changes at the top step, so zero edges
	// land between periods and the old duty always completes.
	logic pwm_reg;
	assign pwm_out = pwm_reg;
	always_ff @(posedge ref_clk) begin
		if (srst)
			pwm_reg <= 1'b0;
		else if (clk_en && eff_tick) begin
			if (center_mode) begin
				if (channel_compare_value == `PDB_ZERO)
					pwm_reg <= 1'b0;
				else if (channel_compare_value >= counter_modulo_limit)
					pwm_reg <= 1'b1;
				else if (cif.dir == pdb_pkg::PDB_DOWN && cif.count - `PDB_ONE == channel_compare_value)
					pwm_reg <= 1'b1;
				else if (cif.dir == pdb_pkg::PDB_UP && cif.count + `PDB_ONE == channel_compare_value)
					pwm_reg <= 1'b0;
			end else if (cif.period_start)
				pwm_reg <= channel_compare_value != `PDB_ZERO;
			else if (cif.count + `PDB_ONE == channel_compare_value)
				pwm_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	property p_ctrl_discard;
		@(posedge ref_clk) disable iff (srst)
		clk_en && timer_status_control_wr |=> !value_pending;
	endproperty
	ctrl_wr_discard_a: assert property (p_ctrl_discard) else $error("Control write kept value");

	sequence s_armed_waiting;
		clk_en && clk_on && wr_state_reg == pdb_pkg::PDB_ARMED && !cif.at_top_step
			&& !timer_status_control_wr && !value_wr_lo;
	endsequence
	value_held_a: assert property (@(posedge ref_clk) disable iff (srst)
		s_armed_waiting |=> $stable(channel_compare_value)) else $error("Value moved early");
	top_step_move_a: assert property (@(posedge ref_clk) disable iff (srst)
		clk_en && take_now && !timer_status_control_wr |=> channel_compare_value == $past(buf_reg))
		else $error("Value not moved at update point");
	no_clk_now_a: assert property (@(posedge ref_clk) disable iff (srst)
		clk_en && !clk_on && wr_state_reg == pdb_pkg::PDB_LOW_HELD && value_wr_hi
		&& !timer_status_control_wr ##1 clk_en && !clk_on && !timer_status_control_wr
		&& !value_wr_lo |=> !value_pending)
		else $error("Immediate update missing");
	free_top_a: assert property (@(posedge ref_clk) disable iff (srst)
		cif.at_top_step && counter_modulo_limit == `PDB_ZERO |-> cif.count == `PDB_FREE_PRE)
		else $error("Free-run update point wrong");
	low_pending_a: assert property (@(posedge ref_clk) disable iff (srst)
		clk_en && value_wr_lo && !value_wr_hi && !timer_status_control_wr |=> value_pending)
		else $error("First byte not pending");
	mod_bdm_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
		clk_en && timer_status_control_wr && background_debug_mode |=> !modulo_pending)
		else $error("Debug control write kept modulo half");
	full_duty_a: assert property (@(posedge ref_clk) disable iff (srst)
		clk_en && eff_tick && center_mode && channel_compare_value != `PDB_ZERO
		&& channel_compare_value >= counter_modulo_limit |=> pwm_out)
		else $error("Full duty not held");
endmodule : pdb_duty_update

//--- test/tb_top.sv
// Self-checking bench for the buffered duty update block
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
	$display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
	logic        ref_clk, srst, clk_en, tick, center_mode, background_debug_mode;
	logic [1:0]  counter_clock_source_select;
	logic [4:0]  strb;
	logic [7:0]  wr_data;
	logic [15:0] channel_compare_value, counter_modulo_limit, count;
	logic        pwm_out, value_pending, modulo_pending;
	int          miscompares, checks_done, ones;
	////////////////////////////////////////////////////////////////////////////////
	pdb_duty_update i_dut (
		.ref_clk                    (ref_clk),
		.srst                       (srst),
		.clk_en                     (clk_en),
		.tick                       (tick),
		.counter_clock_source_select(counter_clock_source_select),
		.center_mode                (center_mode),
		.background_debug_mode      (background_debug_mode),
		.timer_status_control_wr    (strb[4]),
		.value_wr_lo                (strb[0]),
		.value_wr_hi                (strb[1]),
		.modulo_wr_lo               (strb[2]),
		.modulo_wr_hi               (strb[3]),
		.wr_data                    (wr_data),
		.channel_compare_value      (channel_compare_value),
		.counter_modulo_limit       (counter_modulo_limit),
		.count                      (count),
		.pwm_out                    (pwm_out),
		.value_pending              (value_pending),
		.modulo_pending             (modulo_pending)
	);
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// Strobe k: 0 value low, 1 value high, 2 modulo low, 3 modulo high, 4 control
	task automatic wr(input int k, input logic [7:0] d);
		@(negedge ref_clk);
		strb = 5'h00;
		strb[k] = 1'b1;
		wr_data = d;
		@(negedge ref_clk);
		strb = 5'h00;
	endtask : wr
	task automatic pair(input int k, input logic [15:0] v);
		wr(k, v[7:0]);
		wr(k + 1, v[15:8]);
	endtask : pair
	// Waits for a count value, counting active output cycles meanwhile
	task automatic wait_cnt(input logic [15:0] v);
		ones = 0;
		for (int i = 0; i < 70000 && count !== v; i++) begin
			@(negedge ref_clk);
			ones += (pwm_out === 1'b1);
		end
		`CHK(count, v)
	endtask : wait_cnt
	task automatic measure(input int n);
		ones = 0;
		repeat (n) begin
			@(negedge ref_clk);
			ones += (pwm_out === 1'b1);
		end
	endtask : measure
	task automatic tally_and_finish;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		// Room for the full free-running wrap plus the short scenarios
		repeat (90000) @(posedge ref_clk);
		miscompares++;
		tally_and_finish();
	end
	initial begin
		srst = 1'b1; clk_en = 1'b1; tick = 1'b1; center_mode = 1'b0;
		background_debug_mode = 1'b0; counter_clock_source_select = 2'h0;
		strb = 5'h00; wr_data = 8'h00; miscompares = 0; checks_done = 0;
		repeat (20) @(negedge ref_clk);
		srst = 1'b0;
		`CHK({channel_compare_value, counter_modulo_limit, value_pending}, 33'h0)
		// No clock source: a finished pair lands at once
		pair(0, 16'h1234);
		// The armed value lands one edge after the high byte is taken
		@(negedge ref_clk);
		`CHK(channel_compare_value, 16'h1234)
		`CHK(value_pending, 1'b0)
		wr(1, 8'hab);
		`CHK(channel_compare_value, 16'h1234)
		wr(0, 8'h55);
		`CHK(value_pending, 1'b1)
		wr(4, 8'h00);
		wr(1, 8'h66);
		`CHK(channel_compare_value, 16'h1234)
		background_debug_mode = 1'b1;
		wr(2, 8'h10);
		`CHK(modulo_pending, 1'b1)
		wr(4, 8'h00);
		`CHK(modulo_pending, 1'b0)
		background_debug_mode = 1'b0;
		pair(2, 16'h0010);
		`CHK(counter_modulo_limit, 16'h0010)
		// Edge-aligned with a running counter: value waits for the top step
		counter_clock_source_select = 2'h1;
		wr(4, 8'h00);
		pair(0, 16'h0005);
		wait_cnt(16'h000f);
		`CHK(channel_compare_value, 16'h1234)
		`CHK(value_pending, 1'b1)
		@(negedge ref_clk);
		@(negedge ref_clk);
		`CHK(channel_compare_value, 16'h0005)
		// Center-aligned: full, near-full, off, then back on at a period start
		center_mode = 1'b1;
		pair(0, 16'h0010);
		wait_cnt(16'h000f);
		`CHK(channel_compare_value, 16'h0005)
		repeat (2) @(negedge ref_clk);
		`CHK(channel_compare_value, 16'h0010)
		measure(64);
		`CHK(ones, 64)
		pair(0, 16'h000f);
		wait_cnt(16'h0010);
		repeat (2) @(negedge ref_clk);
		measure(64);
		`CHK(ones > 0 && ones < 64, 1'b1)
		pair(0, 16'h0000);
		wait_cnt(16'h0001);
		wait_cnt(16'h0010);
		`CHK(ones > 0, 1'b1)
		repeat (2) @(negedge ref_clk);
		measure(64);
		`CHK(ones, 0)
		pair(0, 16'h0008);
		wait_cnt(16'h0010);
		`CHK(ones, 0)
		repeat (2) @(negedge ref_clk);
		measure(64);
		`CHK(ones > 0, 1'b1)
		// Free-running counter: update at the step into all ones
		center_mode = 1'b0;
		pair(2, 16'h0000);
		pair(0, 16'h0abc);
		wait_cnt(16'hfffe);
		`CHK(channel_compare_value, 16'h0008)
		repeat (2) @(negedge ref_clk);
		`CHK(channel_compare_value, 16'h0abc)
		tally_and_finish();
	end
endmodule : tb_top
